// ---- rtl/aer_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the correctable error registers
`ifndef AER_CFG_SVH
`define AER_CFG_SVH
`define AER_OFF_STATUS     12'h110
`define AER_OFF_MASK       12'h114
`define AER_OFF_CAPCTL     12'h118
`define AER_OFF_IRQ_STAT   12'h130
`define AER_OFF_IRQ_MASK   12'h134
`define AER_BIT_RXERR      0
`define AER_BIT_BADTLP     6
`define AER_BIT_BADDLLP    7
`define AER_BIT_ROLLOVER   8
`define AER_BIT_REPLAYTO   12
`define AER_BIT_ADVISORY   13
`define AER_COR_IMPL       32'h0000_31C1
`define AER_RST_STATUS     32'h0000_0000
`define AER_RST_MASK       32'h0000_2000
`define AER_RST_CAPCTL     32'h0000_00A0
`define AER_RST_IRQ_MASK   32'h0000_0000
`define AER_BIT_CHK_EN     8
`define AER_BIT_CHK_CAP    7
`define AER_BIT_GEN_EN     6
`define AER_BIT_GEN_CAP    5
`define AER_PTR_MSB        4
`define AER_UNC_UR         5'h14
`define AER_UNC_ECRC       5'h13
`define AER_UNC_MALFORMED  5'h12
`define AER_UNC_LINKPROTO  5'h04
`define AER_CYC_RESP       1
`endif

// ---- rtl/aer_pkg.sv ----
// Types shared by the correctable error register block
package aer_pkg;
	typedef enum logic [1:0] {
		AER_R_IDLE = 2'b00,
		AER_R_RESP = 2'b01
	} aer_rd_state_type;
	typedef enum logic [1:0] {
		AER_W_IDLE = 2'b00,
		AER_W_HAVE_A = 2'b01,
		AER_W_HAVE_D = 2'b10,
		AER_W_RESP = 2'b11
	} aer_wr_state_type;
endpackage

// ---- rtl/aer_sticky_bit.sv ----
// One sticky write-one-to-clear status bit where a set wins over a clear
module aer_sticky_bit (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	// Set and clear
	input  wire logic i_set,
	input  wire logic i_clr,
	// State
	output logic      o_q
);
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_q <= 1'b0;
		end else if (i_set) begin
			o_q <= 1'b1;
		end else if (i_clr) begin
			o_q <= 1'b0;
		end
	end
endmodule

// ---- rtl/aer_cor_regs.sv ----
// Correctable error status, mask and capability/control registers on AXI4-Lite
// Overview of operation
// - Bad DLLP CRC sets status bit 7
// - Physical error during TLP sets bit 6
// - EDB TLP without inverted CRC sets bit 6
// - TLP CRC mismatch sets bit 6
// - Advisory bit 13 sticky, write-one clears
// - Replay timer expiry sticky in bit 12
// - Status at 0x110; rollover 8, receiver 0
// - Mask at 0x114, resets with bit 13
// - Replay timeout mask bit 12 writable, zero
// - Bit 8 enables ECRC checking, resets 0
// - Bit 6 enables ECRC generation, resets 0
// - Bit 7 reads one: check capable
// - Bit 5 reads one: generate capable
// - Bits 4:0 hold first uncorrectable position
// - Pointer may name 20, 19, 18, 4; the code latches any position 0..31
//
// Local design decision: the AXI4-Lite slave port.
`include "aer_cfg.svh"
module aer_cor_regs
	import aer_pkg::*;
(
	// Clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_RST_N,
	// AXI4-Lite write address, data and response
	input  wire logic        I_AWVALID,
	output logic             O_AWREADY,
	input  wire logic [11:0] I_AWADDR,
	input  wire logic        I_WVALID,
	output logic             O_WREADY,
	input  wire logic [31:0] I_WDATA,
	input  wire logic [3:0]  I_WSTRB,
	output logic             O_BVALID,
	input  wire logic        I_BREADY,
	output logic [1:0]       O_BRESP,
	// AXI4-Lite read
	input  wire logic        I_ARVALID,
	output logic             O_ARREADY,
	input  wire logic [11:0] I_ARADDR,
	output logic             O_RVALID,
	input  wire logic        I_RREADY,
	output logic [31:0]      O_RDATA,
	output logic [1:0]       O_RRESP,
	// Link-layer error events, one-cycle pulses
	input  wire logic        I_DLLP_DONE,
	input  wire logic        I_DLLP_CRC_BAD,
	input  wire logic        I_TLP_DONE,
	input  wire logic        I_TLP_PHY_ERR,
	input  wire logic        I_TLP_EDB,
	input  wire logic [31:0] I_TLP_CRC_CALC,
	input  wire logic [31:0] I_TLP_CRC_RECV,
	input  wire logic        I_RECEIVER_ERR,
	input  wire logic        I_REPLAY_TIMER_EXPIRED,
	input  wire logic        I_REPLAY_COUNT_ROLLOVER,
	input  wire logic        I_ADVISORY_NONFATAL,
	// First uncorrectable error capture
	input  wire logic        I_UNC_ERR_VALID,
	input  wire logic [4:0]  I_UNC_ERR_POS,
	// Controls and reporting
	output logic             O_CRC_CHECK_ENABLE,
	output logic             O_CRC_GEN_ENABLE,
	output logic             O_COR_MSG,
	output logic             O_IRQ
);
	localparam logic [31:0] IMPL = `AER_COR_IMPL;

	logic [31:0] ev_nxt;
	logic [31:0] status_r;
	logic [31:0] w1c_clr;
	logic [31:0] mask_r;
	logic        chk_en_r;
	logic        gen_en_r;
	logic [4:0]  first_ptr_r;
	logic        ptr_held_r;
	logic [4:0]  irq_stat_r;
	logic [4:0]  irq_mask_r;
	logic [4:0]  irq_ev;
	logic        irq_rd_clr;
	logic        tlp_bad;

	aer_wr_state_type wst_r;
	aer_rd_state_type rst_r;
	logic [11:0] waddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic [11:0] raddr_r;
	logic        wr_fire;
	logic        rd_fire;
	logic [31:0] rd_val;
	logic        rd_hit;
	logic        wr_hit;

	// Link-side error decode; TLP checks go in priority: PHY error, then EDB with inverted CRC, then plain CRC compare
	always_comb begin
		tlp_bad = 1'b0;
		if (I_TLP_DONE) begin
			if (I_TLP_PHY_ERR) begin
				tlp_bad = 1'b1;
			end else if (I_TLP_EDB) begin
				tlp_bad = (I_TLP_CRC_RECV != ~I_TLP_CRC_CALC);
			end else begin
				tlp_bad = (I_TLP_CRC_RECV != I_TLP_CRC_CALC);
			end
		end
		ev_nxt = 32'h0000_0000;
		ev_nxt[`AER_BIT_BADDLLP] = I_DLLP_DONE & I_DLLP_CRC_BAD;
		ev_nxt[`AER_BIT_BADTLP] = tlp_bad;
		ev_nxt[`AER_BIT_RXERR] = I_RECEIVER_ERR;
		ev_nxt[`AER_BIT_ROLLOVER] = I_REPLAY_COUNT_ROLLOVER;
		ev_nxt[`AER_BIT_REPLAYTO] = I_REPLAY_TIMER_EXPIRED;
		ev_nxt[`AER_BIT_ADVISORY] = I_ADVISORY_NONFATAL;
	end

	// Write-one-to-clear strobes, only on implemented bits
	always_comb begin
		w1c_clr = 32'h0000_0000;
		if (wr_fire && waddr_r == `AER_OFF_STATUS) begin
			for (int b = 0; b < 32; b++) begin
				w1c_clr[b] = wdata_r[b] & wstrb_r[b / 8] & IMPL[b];
			end
		end
	end

	// Only implemented positions get a flop; the rest stay tied to zero
	genvar g;
	generate
		for (g = 0; g < 32; g++) begin : g_stat
			if (IMPL[g]) begin : g_impl
				aer_sticky_bit u_bit (
					.i_clk   (I_CLK),
					.i_rst_n (I_RST_N),
					.i_set   (ev_nxt[g]),
					.i_clr   (w1c_clr[g]),
					.o_q     (status_r[g])
				);
			end else begin : g_rsvd
				assign status_r[g] = 1'b0;
			end
		end
	endgenerate

	// Mask register; reserved positions never take a write
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			mask_r <= `AER_RST_MASK;
		end else if (wr_fire && waddr_r == `AER_OFF_MASK) begin
			for (int b = 0; b < 32; b++) begin
				if (wstrb_r[b / 8] && IMPL[b]) begin
					mask_r[b] <= wdata_r[b];
				end
			end
		end
	end

	// ECRC enables
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			chk_en_r <= 1'b0;
			gen_en_r <= 1'b0;
		end else if (wr_fire && waddr_r == `AER_OFF_CAPCTL) begin
			if (wstrb_r[1]) begin
				chk_en_r <= wdata_r[`AER_BIT_CHK_EN];
			end
			if (wstrb_r[0]) begin
				gen_en_r <= wdata_r[`AER_BIT_GEN_EN];
			end
		end
	end

	// First-error pointer latches once and holds; any position 0..31 is accepted
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			first_ptr_r <= 5'h00;
			ptr_held_r  <= 1'b0;
		end else if (I_UNC_ERR_VALID && !ptr_held_r) begin
			first_ptr_r <= I_UNC_ERR_POS;
			ptr_held_r  <= 1'b1;
		end
	end

	assign O_CRC_CHECK_ENABLE = chk_en_r;
	assign O_CRC_GEN_ENABLE   = gen_en_r;
	// Message is a level: any recorded error that is not masked
	assign O_COR_MSG = |(status_r & ~mask_r);

	// Interrupt events: bad DLLP, bad TLP, receiver, replay, pointer capture
	assign irq_ev = {I_UNC_ERR_VALID & ~ptr_held_r, ev_nxt[`AER_BIT_REPLAYTO],
		ev_nxt[`AER_BIT_RXERR], ev_nxt[`AER_BIT_BADTLP], ev_nxt[`AER_BIT_BADDLLP]};
	assign irq_rd_clr = rd_fire && raddr_r == `AER_OFF_IRQ_STAT;

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			irq_stat_r <= 5'h00;
		end else if (irq_rd_clr) begin
			// Clear only what the read reported; an event after the snapshot stays pending
			irq_stat_r <= (irq_stat_r & ~O_RDATA[4:0]) | irq_ev;
		end else begin
			irq_stat_r <= irq_stat_r | irq_ev;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			irq_mask_r <= 5'(`AER_RST_IRQ_MASK);
		end else if (wr_fire && waddr_r == `AER_OFF_IRQ_MASK && wstrb_r[0]) begin
			irq_mask_r <= wdata_r[4:0];
		end
	end

	assign O_IRQ = |(irq_stat_r & irq_mask_r);

	// Write channel: address and data in either order, then one response
	assign O_AWREADY = (wst_r == AER_W_IDLE) || (wst_r == AER_W_HAVE_D);
	assign O_WREADY  = (wst_r == AER_W_IDLE) || (wst_r == AER_W_HAVE_A);
	assign wr_fire   = (wst_r == AER_W_RESP) && I_BREADY;

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			wst_r   <= AER_W_IDLE;
			waddr_r <= 12'h000;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else begin
			if (I_AWVALID && O_AWREADY) begin
				waddr_r <= {I_AWADDR[11:2], 2'b00};
			end
			if (I_WVALID && O_WREADY) begin
				wdata_r <= I_WDATA;
				wstrb_r <= I_WSTRB;
			end
			case (wst_r)
				AER_W_IDLE: begin
					if (I_AWVALID && I_WVALID) begin
						wst_r <= AER_W_RESP;
					end else if (I_AWVALID) begin
						wst_r <= AER_W_HAVE_A;
					end else if (I_WVALID) begin
						wst_r <= AER_W_HAVE_D;
					end
				end
				AER_W_HAVE_A: begin
					if (I_WVALID) begin
						wst_r <= AER_W_RESP;
					end
				end
				AER_W_HAVE_D: begin
					if (I_AWVALID) begin
						wst_r <= AER_W_RESP;
					end
				end
				AER_W_RESP: begin
					if (I_BREADY) begin
						wst_r <= AER_W_IDLE;
					end
				end
				default: wst_r <= AER_W_IDLE;
			endcase
		end
	end

	always_comb begin
		case (waddr_r)
			`AER_OFF_STATUS, `AER_OFF_MASK, `AER_OFF_CAPCTL,
			`AER_OFF_IRQ_STAT, `AER_OFF_IRQ_MASK: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	assign O_BVALID = (wst_r == AER_W_RESP);
	// Unmapped addresses answer DECERR and change nothing
	assign O_BRESP  = wr_hit ? 2'b00 : 2'b11;

	// Read channel: address taken and data registered on the same edge, valid the next cycle
	assign O_ARREADY = (rst_r == AER_R_IDLE);
	assign rd_fire   = (rst_r == AER_R_RESP) && I_RREADY;

	always_comb begin
		rd_hit = 1'b1;
		rd_val = 32'h0000_0000;
		case (I_ARADDR & 12'hFFC)
			`AER_OFF_STATUS:   rd_val = status_r;
			`AER_OFF_MASK:     rd_val = mask_r & IMPL;
			`AER_OFF_CAPCTL: begin
				rd_val[`AER_BIT_CHK_EN]   = chk_en_r;
				rd_val[`AER_BIT_CHK_CAP]  = 1'b1;
				rd_val[`AER_BIT_GEN_EN]   = gen_en_r;
				rd_val[`AER_BIT_GEN_CAP]  = 1'b1;
				rd_val[`AER_PTR_MSB:0]    = first_ptr_r;
			end
			`AER_OFF_IRQ_STAT: rd_val[4:0] = irq_stat_r;
			`AER_OFF_IRQ_MASK: rd_val[4:0] = irq_mask_r;
			default:           rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rst_r   <= AER_R_IDLE;
			raddr_r <= 12'h000;
			O_RDATA <= 32'h0000_0000;
			O_RRESP <= 2'b00;
		end else begin
			case (rst_r)
				AER_R_IDLE: begin
					if (I_ARVALID) begin
						raddr_r <= I_ARADDR & 12'hFFC;
						O_RDATA <= rd_val;
						O_RRESP <= rd_hit ? 2'b00 : 2'b11;
						rst_r   <= AER_R_RESP;
					end
				end
				AER_R_RESP: begin
					if (I_RREADY) begin
						rst_r <= AER_R_IDLE;
					end
				end
				default: rst_r <= AER_R_IDLE;
			endcase
		end
	end

	assign O_RVALID = (rst_r == AER_R_RESP);

	// Checks
	a_dllp_sets_bit: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		I_DLLP_DONE && I_DLLP_CRC_BAD |=> status_r[`AER_BIT_BADDLLP])
		else $error("bad DLLP not recorded");
	a_phy_sets_tlp: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		I_TLP_DONE && I_TLP_PHY_ERR |=> status_r[`AER_BIT_BADTLP])
		else $error("phy TLP error not recorded");
	a_edb_inverted_ok: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		I_TLP_DONE && !I_TLP_PHY_ERR && I_TLP_EDB
		&& I_TLP_CRC_RECV == ~I_TLP_CRC_CALC && !status_r[`AER_BIT_BADTLP]
		|=> !status_r[`AER_BIT_BADTLP])
		else $error("nullified TLP flagged bad");
	a_crc_mismatch_tlp: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		I_TLP_DONE && !I_TLP_EDB && I_TLP_CRC_RECV != I_TLP_CRC_CALC
		|=> status_r[`AER_BIT_BADTLP])
		else $error("TLP CRC mismatch not recorded");
	a_status_sticky: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		status_r[`AER_BIT_ADVISORY] && !w1c_clr[`AER_BIT_ADVISORY]
		|=> status_r[`AER_BIT_ADVISORY])
		else $error("advisory bit lost without clear");
	a_replay_to_set: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		I_REPLAY_TIMER_EXPIRED |=> status_r[`AER_BIT_REPLAYTO])
		else $error("replay timeout not recorded");
	a_rsvd_zero: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		((status_r | mask_r) & ~IMPL) == 32'h0000_0000)
		else $error("reserved bit set");
	a_ptr_holds: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		ptr_held_r |=> $stable(first_ptr_r) && ptr_held_r)
		else $error("first error pointer changed");
	a_msg_masked: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		|(ev_nxt & mask_r) |=> |(status_r & $past(mask_r)))
		else $error("masked error not recorded");
	a_cap_read: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		O_ARREADY && I_ARVALID && (I_ARADDR & 12'hFFC) == `AER_OFF_CAPCTL
		|=> O_RDATA[`AER_BIT_CHK_CAP] && O_RDATA[`AER_BIT_GEN_CAP])
		else $error("capability bits not read as one");
	c_bad_tlp: cover property (@(posedge I_CLK) tlp_bad);
	c_w1c_write: cover property (@(posedge I_CLK) |w1c_clr);
	c_irq: cover property (@(posedge I_CLK) O_IRQ);
	c_set_clr_same: cover property (@(posedge I_CLK) |(ev_nxt & w1c_clr));
endmodule

// ---- sim/aer_link_partner.sv ----
// Link partner model that raises packet and error events toward the register block
module aer_link_partner (
	// Clock
	input  wire logic   i_clk,
	// Packet and event outputs
	output logic        o_dllp_done,
	output logic        o_dllp_bad,
	output logic        o_tlp_done,
	output logic        o_tlp_phy,
	output logic        o_tlp_edb,
	output logic [31:0] o_crc_calc,
	output logic [31:0] o_crc_recv,
	output logic [3:0]  o_ev,
	output logic        o_unc_v,
	output logic [4:0]  o_unc_pos
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{o_dllp_done, o_dllp_bad, o_tlp_done, o_tlp_phy, o_tlp_edb, o_unc_v} = 6'h00;
		{o_crc_calc, o_crc_recv} = 64'h0;
		o_ev = 4'h0;
		o_unc_pos = 5'h00;
	end
	// Qualifiers flip after each packet so a stale value can never pass as fresh
	task automatic dllp(input logic bad);
		@(posedge i_clk);
		o_dllp_done <= 1'b1;
		o_dllp_bad <= bad;
		@(posedge i_clk);
		o_dllp_done <= 1'b0;
		o_dllp_bad <= ~bad;
	endtask
	task automatic tlp(input logic phy, input logic edb, input logic [31:0] c, input logic [31:0] r);
		@(posedge i_clk);
		{o_tlp_done, o_tlp_phy, o_tlp_edb} <= {1'b1, phy, edb};
		{o_crc_calc, o_crc_recv} <= {c, r};
		@(posedge i_clk);
		{o_tlp_done, o_tlp_phy, o_tlp_edb} <= {1'b0, ~phy, ~edb};
		{o_crc_calc, o_crc_recv} <= {~c, ~r};
	endtask
	task automatic ev(input int k);
		@(posedge i_clk);
		o_ev[k] <= 1'b1;
		@(posedge i_clk);
		o_ev[k] <= 1'b0;
	endtask
	task automatic unc(input logic [4:0] p);
		@(posedge i_clk);
		o_unc_v <= 1'b1;
		o_unc_pos <= p;
		@(posedge i_clk);
		o_unc_v <= 1'b0;
		o_unc_pos <= ~p;
	endtask
endmodule

// ---- sim/aer_correctable_error_regs_tb.sv ----
// Self-checking bench for the correctable error register block
module aer_correctable_error_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst_n, awv, wv, bre, arv, rre, awr, wr_, bv, arr, rv;
	logic        cen_o, gen_o, msg, irq, dd, db, td, tp, te, uv;
	logic [11:0] awa, ara;
	logic [31:0] wd, rdat, cc, cr, st, mk, is, im;
	logic [1:0]  br, rr;
	logic [3:0]  ev;
	logic [3:0]  ws, wl;
	logic        ev_rx, ev_rt, ev_ro, ev_an;
	logic [4:0]  up, ptr;
	logic        cen, gen;
	int          errors, checks_done, seed;
	logic [4:0]  codes[4] = '{5'h14, 5'h13, 5'h12, 5'h04};
	assign {ev_an, ev_ro, ev_rt, ev_rx} = ev;
	always #2 clk = ~clk;
	aer_cor_regs uut (.I_CLK(clk), .I_RST_N(rst_n), .I_AWVALID(awv), .O_AWREADY(awr),
		.I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wr_), .I_WDATA(wd), .I_WSTRB(ws),
		.O_BVALID(bv), .I_BREADY(bre), .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(arr),
		.I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rre), .O_RDATA(rdat), .O_RRESP(rr),
		.I_DLLP_DONE(dd), .I_DLLP_CRC_BAD(db), .I_TLP_DONE(td), .I_TLP_PHY_ERR(tp),
		.I_TLP_EDB(te), .I_TLP_CRC_CALC(cc), .I_TLP_CRC_RECV(cr), .I_RECEIVER_ERR(ev_rx),
		.I_REPLAY_TIMER_EXPIRED(ev_rt), .I_REPLAY_COUNT_ROLLOVER(ev_ro),
		.I_ADVISORY_NONFATAL(ev_an), .I_UNC_ERR_VALID(uv), .I_UNC_ERR_POS(up),
		.O_CRC_CHECK_ENABLE(cen_o), .O_CRC_GEN_ENABLE(gen_o), .O_COR_MSG(msg), .O_IRQ(irq));
	aer_link_partner lp (.i_clk(clk), .o_dllp_done(dd), .o_dllp_bad(db), .o_tlp_done(td),
		.o_tlp_phy(tp), .o_tlp_edb(te), .o_crc_calc(cc), .o_crc_recv(cr), .o_ev(ev),
		.o_unc_v(uv), .o_unc_pos(up));
	task automatic end_sim;
		$display("errors=%0d checks=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic cmp_out;
		cmp({28'h0, msg, irq, cen_o, gen_o}, {28'h0, |(st & ~mk), |(is & im), cen, gen}, "out");
	endtask
	function automatic logic [1:0] er(input logic [11:0] a);
		return (a inside {12'h110, 12'h114, 12'h118, 12'h130, 12'h134}) ? 2'h0 : 2'h3;
	endfunction
	function automatic logic [31:0] ex(input logic [11:0] a);
		case (a)
			12'h110: return st;
			12'h114: return mk;
			12'h118: return {23'h0, cen, 1'b1, gen, 1'b1, ptr};
			12'h130: return is;
			12'h134: return im;
			default: return 32'h0;
		endcase
	endfunction
	// Bounded wait at the falling edge, where every output of the last edge has settled
	task automatic tick(inout int n);
		@(negedge clk);
		n++;
		if (n > 100) begin
			errors++;
			$display("wrong value at %0t: bus hang", $time);
			end_sim;
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		logic ha, hw, ta, tw;
		logic [31:0] lm;
		n = 0;
		{ha, hw} = 2'b00;
		lm = {{8{wl[3]}}, {8{wl[2]}}, {8{wl[1]}}, {8{wl[0]}}};
		@(posedge clk);
		{awv, wv, bre} <= 3'b111;
		ws <= wl;
		awa <= a;
		wd <= d;
		while (!(ha && hw)) begin
			tick(n);
			ta = awv & awr;
			tw = wv & wr_;
			@(posedge clk);
			if (ta) begin
				awv <= 1'b0;
				ha = 1'b1;
			end
			if (tw) begin
				wv <= 1'b0;
				hw = 1'b1;
			end
		end
		do tick(n); while (bv !== 1'b1);
		cmp({30'h0, br}, {30'h0, er(a)}, "bresp");
		@(posedge clk);
		bre <= 1'b0;
		case (a)
			12'h110: st = st & ~(d & lm);
			12'h114: mk = (mk & ~lm) | (d & lm & 32'h0000_31C1);
			12'h118: begin
				if (wl[1]) cen = d[8];
				if (wl[0]) gen = d[6];
			end
			12'h134: if (wl[0]) im = d & 32'h0000_001F;
			default: ;
		endcase
	endtask
	task automatic rd(input logic [11:0] a);
		int n;
		n = 0;
		@(posedge clk);
		{arv, rre} <= 2'b11;
		ara <= a;
		do tick(n); while (arr !== 1'b1);
		@(posedge clk);
		arv <= 1'b0;
		do tick(n); while (rv !== 1'b1);
		cmp(rdat, ex(a), "rdata");
		cmp({30'h0, rr}, {30'h0, er(a)}, "rresp");
		@(posedge clk);
		rre <= 1'b0;
		if (a == 12'h130) is = 32'h0;
	endtask
	task automatic reset;
		rst_n <= 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		{st, is, im, cen, gen, ptr} = 103'h0;
		mk = 32'h0000_2000;
	endtask
	task automatic hit(input int b, input int q);
		st[b] = 1'b1;
		if (q >= 0) is[q] = 1'b1;
	endtask
	initial begin
		logic [31:0] c;
		seed = 32'h7B2BFEEA;
		{awv, wv, bre, arv, rre, rst_n} = 6'h00;
		{awa, ara, wd} = 56'h0;
		{ws, wl} = 8'hFF;
		errors = 0;
		checks_done = 0;
		for (int i = 0; i < 4; i++) begin
			reset;
			rd(12'h110);
			rd(12'h114);
			rd(12'h118);
			rd(12'h200);
			lp.unc(codes[i]);
			ptr = codes[i];
			is[4] = 1'b1;
			lp.unc(codes[3 - i]);
			rd(12'h118);
			rd(12'h130);
		end
		wr(12'h200, 32'hFFFF_FFFF);
		for (int k = 0; k < 11; k++) begin
			c = $random(seed);
			wl = 4'hF;
			wr(12'h110, 32'hFFFF_FFFF);
			// Random byte lanes: a lane left out must keep its old bits
			wl = c[31:28];
			wr(12'h114, $random(seed));
			wr(12'h118, $random(seed));
			wr(12'h134, $random(seed));
			wl = 4'hF;
			rd(12'h130);
			case (k)
				0: begin lp.dllp(1'b1); hit(7, 0); end
				1: lp.dllp(1'b0);
				2: begin lp.tlp(1'b1, 1'b0, c, c); hit(6, 1); end
				3: lp.tlp(1'b0, 1'b1, c, ~c);
				4: begin lp.tlp(1'b0, 1'b1, c, c); hit(6, 1); end
				5: begin lp.tlp(1'b0, 1'b0, c, c ^ 32'h0000_0100); hit(6, 1); end
				6: lp.tlp(1'b0, 1'b0, c, c);
				7: begin lp.ev(0); hit(0, 2); end
				8: begin lp.ev(1); hit(12, 3); end
				9: begin lp.ev(2); hit(8, -1); end
				default: begin lp.ev(3); hit(13, -1); end
			endcase
			@(negedge clk);
			cmp_out;
			rd(12'h110);
			wr(12'h110, 32'h0);
			rd(12'h110);
			rd(12'h114);
			rd(12'h118);
			rd(12'h130);
			@(negedge clk);
			cmp_out;
		end
		end_sim;
	end
endmodule
